// [design/stu_regs.svh]
`ifndef STU_REGS_SVH
`define STU_REGS_SVH

// Register offsets
`define STU_OFF_CTRL     8'h00
`define STU_OFF_STATUS   8'h04
`define STU_OFF_MASK     8'h08
`define STU_OFF_OPT0     8'h0C
`define STU_OFF_OPT2     8'h10
`define STU_OFF_OVFCNT   8'h14
`define STU_OFF_STATE    8'h18

// Field positions
`define STU_CTRL_EN      0
`define STU_ST_OVF       0
`define STU_ST_SENT      1
`define STU_IFSEL_LO     29
`define STU_IFSEL_HI     30
`define STU_MODE_BIT     1

// Values
`define STU_IFSEL_LINK   2'h1
`define STU_RST_CTRL     1'h1
`define STU_RST_OPT0     32'h0000_0002
`define STU_RST_OPT2     32'h6000_0000

// Timing
`define STU_CLK_MHZ      25.0
`define STU_LINK_MHZ     33
`define STU_LONG_US      1.727
`define STU_SHORT_US     0.576
`define STU_LONG_CYC     (int'($floor(`STU_LONG_US * `STU_CLK_MHZ)))
`define STU_SHORT_CYC    (int'($floor(`STU_SHORT_US * `STU_CLK_MHZ)))

`endif

// [design/stu_pkg.sv]
package stu_pkg;

  typedef enum logic [1:0] {
    KIND_PC,
    KIND_TAG,
    KIND_REG,
    KIND_OVF
  } stu_kind_e;

  typedef struct packed {
    stu_kind_e   kind;
    logic        has_pc;
    logic [4:0]  regnum;
    logic [31:0] value;
    logic [31:0] pc;
  } stu_entry_s;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_RD
  } stu_seq_e;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } stu_tx_e;

endpackage

// [design/stu_fifo_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface stu_fifo_if #(
  parameter int DEPTH = 8
);
  localparam int CW = $clog2(DEPTH) + 1;

  logic                push;
  stu_pkg::stu_entry_s push_data;
  logic                pop;
  stu_pkg::stu_entry_s pop_data;
  logic                empty;
  logic                full;
  logic [CW-1:0]       count;

  modport src (output push, push_data, pop, input pop_data, empty, full, count);
  modport mem (input push, push_data, pop, output pop_data, empty, full, count);
endinterface

`default_nettype wire

// [design/stu_trace_fifo.sv]
`timescale 1ns/100ps
`default_nettype none

module stu_trace_fifo #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Queue port
  stu_fifo_if.mem  f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [DEPTH-1:0][$bits(stu_pkg::stu_entry_s)-1:0] mem;
    logic [AW-1:0]                                      rd;
    logic [AW-1:0]                                      wr;
    logic [CW-1:0]                                      count;
  } stu_fifo_s;

  stu_fifo_s st;
  stu_fifo_s next_st;
  logic      do_push;
  logic      do_pop;

  assign f.pop_data = stu_pkg::stu_entry_s'(st.mem[st.rd]);
  assign f.empty    = (st.count == '0);
  assign f.full     = (st.count == CW'(DEPTH));

  always_comb begin
    next_st = st;
    do_pop  = f.pop && !f.empty;
    do_push = f.push && !f.full;
    if (do_push) begin
      next_st.mem[st.wr] = f.push_data;
      next_st.wr         = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (do_pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.count = st.count + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.count = st.count;

  a_fifo_count_up: assert property (@(posedge core_clk) disable iff (srst)
    f.push && !f.full && !f.pop |=> f.count == $past(f.count) + 1'b1)
    else $error("fifo count did not rise on push");

endmodule // stu_trace_fifo

`default_nettype wire

// [design/stu_trace_unit.sv]
// How it works
// - Queue trace messages, send over debug link
// - No link output while emulator detached
// - Only trace instructions create messages
// - Checkpoint sends program counter, long slot
// - Tag sends 10-bit value, short slot unless it adds program counter
// - Dump sends registers ascending, long slot each
// - Tag and dump may add program counter
// - Slot lengths scaled to 25 MHz core clock cycles
// - Buffer absorbs bursts; full drops counted
// - Interface select reads 01 while attached
// - Option writes store every bit; mode and interface select held while attached
// - Mode select bit reads 0 while attached
// - Eight entries; eighth holds overflow marker
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "stu_regs.svh"

module stu_trace_unit #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Trace instructions
  input  wire logic        checkpoint_pc_instr,
  input  wire logic        tag_immediate_instr,
  input  wire logic        register_dump_instr,
  input  wire logic [31:0] instr_pc,
  input  wire logic [9:0]  tag_value_field,
  input  wire logic [4:0]  dump_lo,
  input  wire logic [4:0]  dump_hi,
  input  wire logic        instr_with_pc,
  output var  logic        instr_busy,
  // Register file read
  output var  logic [4:0]  gpr_addr,
  input  wire logic [31:0] gpr_data,
  // Low pin debug link
  input  wire logic        emu_attach_pin,
  output var  logic [3:0]  link_dout,
  output var  logic        link_frame,
  output var  logic        link_oe_n,
  // Option words
  output var  logic [31:0] option_word_zero,
  output var  logic [31:0] option_word_two,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // Interrupt
  output var  logic        irq
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] LAST_FREE = CW'(DEPTH - 1);
  localparam logic [5:0] SLOT_LONG = 6'(`STU_LONG_CYC);
  localparam logic [5:0] SLOT_SHORT = 6'(`STU_SHORT_CYC);

  typedef struct packed {
    logic                att_s1;
    logic                att;
    logic                en;
    logic [1:0]          status;
    logic [1:0]          mask;
    logic                irq;
    logic [31:0]         opt0;
    logic [31:0]         opt2;
    logic [31:0]         eff0;
    logic [31:0]         eff2;
    logic [31:0]         rdata;
    logic [15:0]         ovf_cnt;
    logic                lock;
    stu_pkg::stu_seq_e   seq;
    logic [4:0]          idx;
    logic [4:0]          hi;
    logic                dpc;
    logic [31:0]         dpc_val;
    logic                busy;
    stu_pkg::stu_tx_e    tx;
    logic [75:0]         sh;
    logic [4:0]          nib;
    logic [5:0]          slot;
    logic [3:0]          dout;
    logic                frame;
    logic                oe_n;
  } stu_state_s;

  stu_state_s          st;
  stu_state_s          next_st;
  stu_pkg::stu_entry_s msg;
  logic                msg_v;
  logic                push;
  stu_pkg::stu_entry_s push_data;
  logic                pop;
  logic                ovf_ev;
  logic                sent_ev;
  logic [1:0]          rd_clr;
  logic [80:0]         pk;

  stu_fifo_if #(.DEPTH(DEPTH)) fi ();

  stu_trace_fifo #(
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .f        (fi)
  );

  assign fi.push      = push;
  assign fi.push_data = push_data;
  assign fi.pop       = pop;

  // Nibble image of one message, count in top bits
  function automatic logic [80:0] pack_msg(input stu_pkg::stu_entry_s e);
    logic [3:0]  hdr;
    logic [75:0] b;
    logic [4:0]  n;
    hdr = {e.kind, e.has_pc, 1'b0};
    b   = {hdr, 72'h0};
    n   = 5'h1;
    case (e.kind)
      stu_pkg::KIND_PC: begin
        b = {hdr, e.pc, 40'h0};
        n = 5'h9;
      end
      stu_pkg::KIND_TAG: begin
        b = {hdr, 2'h0, e.value[9:0], e.pc, 28'h0};
        n = e.has_pc ? 5'hC : 5'h4;
      end
      stu_pkg::KIND_REG: begin
        b = {hdr, 3'h0, e.regnum, e.value, e.pc};
        n = e.has_pc ? 5'h13 : 5'hB;
      end
      default: begin
        b = {hdr, 72'h0};
        n = 5'h1;
      end
    endcase
    return {n, b};
  endfunction

  always_comb begin
    next_st   = st;
    msg       = '0;
    msg_v     = 1'b0;
    push      = 1'b0;
    push_data = '0;
    pop       = 1'b0;
    ovf_ev    = 1'b0;
    sent_ev   = 1'b0;
    rd_clr    = 2'h0;
    pk        = '0;

    // Attach pin synchroniser
    next_st.att_s1 = emu_attach_pin;
    next_st.att    = st.att_s1;

    // Instruction capture and dump sequencing
    case (st.seq)
      stu_pkg::SEQ_IDLE: begin
        if (checkpoint_pc_instr) begin
          msg.kind   = stu_pkg::KIND_PC;
          msg.has_pc = 1'b1;
          msg.pc     = instr_pc;
          msg_v      = 1'b1;
        end else if (tag_immediate_instr) begin
          msg.kind   = stu_pkg::KIND_TAG;
          msg.value  = {22'h0, tag_value_field};
          msg.has_pc = instr_with_pc;
          msg.pc     = instr_pc;
          msg_v      = 1'b1;
        end else if (register_dump_instr) begin
          next_st.seq     = stu_pkg::SEQ_RD;
          next_st.idx     = dump_lo;
          next_st.hi      = dump_hi;
          next_st.dpc     = instr_with_pc;
          next_st.dpc_val = instr_pc;
        end
      end
      stu_pkg::SEQ_RD: begin
        msg.kind   = stu_pkg::KIND_REG;
        msg.regnum = st.idx;
        msg.value  = gpr_data;
        msg.has_pc = st.dpc;
        msg.pc     = st.dpc_val;
        msg_v      = 1'b1;
        if (st.idx >= st.hi) begin
          next_st.seq = stu_pkg::SEQ_IDLE;
        end else begin
          next_st.idx = st.idx + 5'h1;
        end
      end
      default: next_st.seq = stu_pkg::SEQ_IDLE;
    endcase
    next_st.busy = (next_st.seq != stu_pkg::SEQ_IDLE);

    // Queue entry, overflow marker and drops
    if (st.tx == stu_pkg::TX_IDLE && !fi.empty && st.att) begin
      next_st.lock = 1'b0;
    end
    if (msg_v && st.en && st.att) begin
      if (st.lock || fi.full) begin
        ovf_ev = 1'b1;
      end else if (fi.count == LAST_FREE) begin
        push             = 1'b1;
        push_data.kind   = stu_pkg::KIND_OVF;
        next_st.lock     = 1'b1;
        ovf_ev           = 1'b1;
      end else begin
        push      = 1'b1;
        push_data = msg;
      end
    end
    if (ovf_ev && st.ovf_cnt != 16'hFFFF) begin
      next_st.ovf_cnt = st.ovf_cnt + 16'h1;
    end

    // Link transmitter
    case (st.tx)
      stu_pkg::TX_IDLE: begin
        next_st.frame = 1'b0;
        next_st.dout  = 4'h0;
        if (!fi.empty && st.att) begin
          pop          = 1'b1;
          pk           = pack_msg(fi.pop_data);
          next_st.dout = pk[75:72];
          next_st.sh   = {pk[71:0], 4'h0};
          next_st.nib  = pk[80:76] - 5'h1;
          next_st.frame = 1'b1;
          if ((fi.pop_data.kind == stu_pkg::KIND_TAG && !fi.pop_data.has_pc) ||
              fi.pop_data.kind == stu_pkg::KIND_OVF) begin
            next_st.slot = SLOT_SHORT - 6'h1;
          end else begin
            next_st.slot = SLOT_LONG - 6'h1;
          end
          next_st.tx = stu_pkg::TX_SEND;
        end
      end
      stu_pkg::TX_SEND: begin
        if (st.nib != 5'h0) begin
          next_st.dout  = st.sh[75:72];
          next_st.sh    = {st.sh[71:0], 4'h0};
          next_st.nib   = st.nib - 5'h1;
          next_st.frame = 1'b1;
        end else begin
          next_st.dout  = 4'h0;
          next_st.frame = 1'b0;
        end
        if (st.slot == 6'h0) begin
          next_st.tx    = stu_pkg::TX_IDLE;
          next_st.frame = 1'b0;
          next_st.dout  = 4'h0;
          sent_ev       = 1'b1;
        end else begin
          next_st.slot = st.slot - 6'h1;
        end
      end
      default: next_st.tx = stu_pkg::TX_IDLE;
    endcase
    next_st.oe_n = !next_st.att;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `STU_OFF_CTRL) begin
        next_st.en = reg_wdata[`STU_CTRL_EN];
      end else if (reg_addr == `STU_OFF_MASK) begin
        next_st.mask = reg_wdata[1:0];
      end else if (reg_addr == `STU_OFF_OPT0) begin
        next_st.opt0 = reg_wdata;
        if (st.att) begin
          next_st.opt0[`STU_MODE_BIT] = st.opt0[`STU_MODE_BIT];
        end
      end else if (reg_addr == `STU_OFF_OPT2) begin
        next_st.opt2 = reg_wdata;
        if (st.att) begin
          next_st.opt2[`STU_IFSEL_HI:`STU_IFSEL_LO] =
            st.opt2[`STU_IFSEL_HI:`STU_IFSEL_LO];
        end
      end
    end

    // Effective option words
    next_st.eff0 = next_st.opt0;
    next_st.eff2 = next_st.opt2;
    if (next_st.att) begin
      next_st.eff0[`STU_MODE_BIT] = 1'b0;
      next_st.eff2[`STU_IFSEL_HI:`STU_IFSEL_LO] = `STU_IFSEL_LINK;
    end

    // Register reads
    next_st.rdata = 32'h0;
    if (reg_rd) begin
      if (reg_addr == `STU_OFF_CTRL) begin
        next_st.rdata = {31'h0, st.en};
      end else if (reg_addr == `STU_OFF_STATUS) begin
        next_st.rdata = {30'h0, st.status};
        rd_clr        = 2'h3;
      end else if (reg_addr == `STU_OFF_MASK) begin
        next_st.rdata = {30'h0, st.mask};
      end else if (reg_addr == `STU_OFF_OPT0) begin
        next_st.rdata = st.eff0;
      end else if (reg_addr == `STU_OFF_OPT2) begin
        next_st.rdata = st.eff2;
      end else if (reg_addr == `STU_OFF_OVFCNT) begin
        next_st.rdata = {16'h0, st.ovf_cnt};
      end else if (reg_addr == `STU_OFF_STATE) begin
        next_st.rdata = {24'h0, st.lock, st.busy, st.att, st.tx == stu_pkg::TX_SEND,
                         4'(fi.count)};
      end else begin
        next_st.rdata = 32'h0;
      end
    end

    // Sticky status, set wins over read clear
    next_st.status = (st.status & ~rd_clr) | {sent_ev, ovf_ev};
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st      <= '0;
      st.en   <= `STU_RST_CTRL;
      st.opt0 <= `STU_RST_OPT0;
      st.opt2 <= `STU_RST_OPT2;
      st.eff0 <= `STU_RST_OPT0;
      st.eff2 <= `STU_RST_OPT2;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign instr_busy       = st.busy;
  assign gpr_addr         = st.idx;
  assign link_dout        = st.dout;
  assign link_frame       = st.frame;
  assign link_oe_n        = st.oe_n;
  assign option_word_zero = st.eff0;
  assign option_word_two  = st.eff2;
  assign reg_rdata        = st.rdata;
  assign irq              = st.irq;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_detached_quiet: assert property (!st.att |-> link_oe_n && !push)
    else $error("link driven while detached");
  a_marker_stage: assert property (push && push_data.kind == stu_pkg::KIND_OVF
    |-> fi.count == LAST_FREE)
    else $error("overflow marker outside last stage");
  a_locked_drop: assert property (st.lock |-> !push)
    else $error("push while overflow lock held");
  a_ifsel_attached: assert property (st.att |-> option_word_two[30:29] == 2'b01)
    else $error("interface select not link while attached");
  a_mode_attached: assert property (st.att |-> !option_word_zero[1])
    else $error("mode select set while attached");
  a_short_slot: assert property (pop && fi.pop_data.kind == stu_pkg::KIND_TAG
    && !fi.pop_data.has_pc |-> ##14 st.tx == stu_pkg::TX_SEND ##1 st.tx == stu_pkg::TX_IDLE)
    else $error("short slot length wrong");
  a_long_slot: assert property (pop && fi.pop_data.kind == stu_pkg::KIND_PC
    |-> ##43 st.tx == stu_pkg::TX_SEND ##1 st.tx == stu_pkg::TX_IDLE)
    else $error("long slot length wrong");
  a_dump_ascend: assert property (st.seq == stu_pkg::SEQ_RD && st.idx < st.hi
    |=> st.seq == stu_pkg::SEQ_RD && st.idx == $past(st.idx) + 5'h1)
    else $error("dump index not ascending");
  a_sticky_wins: assert property (ovf_ev && reg_rd && reg_addr == `STU_OFF_STATUS
    |=> st.status[0])
    else $error("overflow flag lost on clear");
  a_frame_start: assert property (pop |=> link_frame && !link_oe_n)
    else $error("frame not started after pop");

endmodule // stu_trace_unit

`default_nettype wire

// [bench/stu_emu_model.sv]
`timescale 1ns/100ps
`default_nettype none

module stu_emu_model (
  // Clock and control
  input  wire logic       core_clk,
  input  wire logic       attach_req,
  // Debug link
  output var  logic       emu_attach_pin,
  input  wire logic [3:0] link_dout,
  input  wire logic       link_frame,
  input  wire logic       link_oe_n
);
  logic [79:0] msg_q[$];
  int          len_q[$];
  logic [79:0] acc;
  int          n;
  int          stray;

  assign emu_attach_pin = attach_req;

  initial begin
    acc = '0;
    n = 0;
    stray = 0;
  end

  // Collect nibbles MSB first, one frame per message
  always @(posedge core_clk) begin
    if (link_frame && link_oe_n) begin
      stray = stray + 1;
    end
    if (link_frame && !link_oe_n) begin
      acc = {acc[75:0], link_dout};
      n = n + 1;
    end else if (n != 0) begin
      msg_q.push_back(acc);
      len_q.push_back(n);
      acc = '0;
      n = 0;
    end
  end
endmodule // stu_emu_model

`default_nettype wire

// [bench/test_stu_trace_unit.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stu_regs.svh"

module test_stu_trace_unit;
  logic        core_clk, srst, attach_req, emu_attach_pin, instr_busy, instr_with_pc;
  logic        checkpoint_pc_instr, tag_immediate_instr, register_dump_instr;
  logic        link_frame, link_oe_n, reg_wr, reg_rd, irq;
  logic [31:0] instr_pc, gpr_data, option_word_zero, option_word_two, reg_wdata, reg_rdata;
  logic [9:0]  tag_value_field;
  logic [4:0]  dump_lo, dump_hi, gpr_addr;
  logic [3:0]  link_dout;
  logic [7:0]  reg_addr;
  int          n_mismatch;
  int          check_count;

  assign gpr_data = {16'hC0DE, 11'h000, gpr_addr};

  stu_trace_unit #(.DEPTH(8)) dut_u (
    .core_clk(core_clk), .srst(srst),
    .checkpoint_pc_instr(checkpoint_pc_instr), .tag_immediate_instr(tag_immediate_instr),
    .register_dump_instr(register_dump_instr), .instr_pc(instr_pc),
    .tag_value_field(tag_value_field), .dump_lo(dump_lo), .dump_hi(dump_hi),
    .instr_with_pc(instr_with_pc), .instr_busy(instr_busy),
    .gpr_addr(gpr_addr), .gpr_data(gpr_data), .emu_attach_pin(emu_attach_pin),
    .link_dout(link_dout), .link_frame(link_frame), .link_oe_n(link_oe_n),
    .option_word_zero(option_word_zero), .option_word_two(option_word_two),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  stu_emu_model emu_u (
    .core_clk(core_clk), .attach_req(attach_req), .emu_attach_pin(emu_attach_pin),
    .link_dout(link_dout), .link_frame(link_frame), .link_oe_n(link_oe_n)
  );

  always #20 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [79:0] ex, input logic [79:0] got);
    check_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(nm, 80'(ex), 80'(reg_rdata));
  endtask

  // Strobe stays high until instr_end or the next call
  task automatic instr(input logic [2:0] k, input logic [31:0] pc, input logic [9:0] v,
                       input logic [4:0] lo, input logic [4:0] hi, input logic wp);
    @(posedge core_clk);
    {register_dump_instr, tag_immediate_instr, checkpoint_pc_instr} <= k;
    instr_pc <= pc;
    tag_value_field <= v;
    dump_lo <= lo;
    dump_hi <= hi;
    instr_with_pc <= wp;
  endtask

  task automatic instr_end();
    int k;
    @(posedge core_clk);
    {register_dump_instr, tag_immediate_instr, checkpoint_pc_instr} <= 3'h0;
    k = 0;
    @(negedge core_clk);
    while (instr_busy !== 1'b0 && k < 100) begin
      @(negedge core_clk);
      k++;
    end
    chk("instr_busy", 80'h0, 80'(instr_busy));
  endtask

  // Next frame from the probe, bounded by one slot plus margin
  task automatic get_msg(input string nm, input logic [79:0] ev, input int el, input int lim);
    int k;
    k = 0;
    while (emu_u.len_q.size() == 0 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (emu_u.len_q.size() == 0) begin
      n_mismatch++;
      check_count++;
      $display("MISMATCH %s expected frame seen none", nm);
    end else begin
      chk(nm, ev, emu_u.msg_q.pop_front());
      chk({nm, "_len"}, 80'(el), 80'(emu_u.len_q.pop_front()));
    end
  endtask

  task automatic t_reset();
    chk("oe_n", 80'h1, 80'(link_oe_n));
    chk("irq", 80'h0, 80'(irq));
    chk("opt0", 80'(`STU_RST_OPT0), 80'(option_word_zero));
    chk("opt2", 80'(`STU_RST_OPT2), 80'(option_word_two));
    rchk("ctrl", `STU_OFF_CTRL, 32'h0000_0001);
    rchk("unmapped", 8'h1C, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_detached();
    instr(3'h2, 32'h0000_0100, 10'h155, 5'h00, 5'h00, 1'b0);
    instr_end();
    repeat (30) @(posedge core_clk);
    chk("stray", 80'h0, 80'(emu_u.stray));
    chk("frames", 80'h0, 80'(emu_u.len_q.size()));
    rchk("state", `STU_OFF_STATE, 32'h0000_0000);
    $display("test detached done");
  endtask

  task automatic t_attach();
    @(posedge core_clk);
    attach_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk("oe_n_att", 80'h0, 80'(link_oe_n));
    chk("ifsel", 80'h1, 80'(option_word_two[30:29]));
    chk("mode", 80'h0, 80'(option_word_zero[1]));
    wr(`STU_OFF_OPT2, 32'h0000_0000);
    rchk("opt2_wr", `STU_OFF_OPT2, 32'h2000_0000);
    wr(`STU_OFF_OPT0, 32'h0000_0001);
    rchk("opt0_wr", `STU_OFF_OPT0, 32'h0000_0001);
    rchk("state_att", `STU_OFF_STATE, 32'h0000_0020);
    $display("test attach done");
  endtask

  task automatic t_instr();
    wr(`STU_OFF_MASK, 32'h0000_0000);
    instr(3'h1, 32'h0000_1234, 10'h000, 5'h00, 5'h00, 1'b0);
    instr(3'h2, 32'h0000_2000, 10'h3A5, 5'h00, 5'h00, 1'b0);
    instr(3'h2, 32'h2000_0010, 10'h155, 5'h00, 5'h00, 1'b1);
    instr_end();
    get_msg("cp", {4'h2, 32'h0000_1234}, 9, 50);
    get_msg("tag", {4'h4, 12'h3A5}, 4, 50);
    get_msg("tag_pc", {4'h6, 12'h155, 32'h2000_0010}, 12, 50);
    instr(3'h4, 32'h0000_3000, 10'h000, 5'h03, 5'h04, 1'b0);
    instr_end();
    get_msg("reg3", {4'h8, 8'h03, 32'hC0DE_0003}, 11, 50);
    get_msg("reg4", {4'h8, 8'h04, 32'hC0DE_0004}, 11, 50);
    instr(3'h4, 32'h0000_4000, 10'h000, 5'h07, 5'h07, 1'b1);
    instr_end();
    get_msg("reg7", {4'hA, 8'h07, 32'hC0DE_0007, 32'h0000_4000}, 19, 50);
    repeat (60) @(posedge core_clk);
    chk("quiet", 80'h0, 80'(emu_u.len_q.size()));
    chk("irq_masked", 80'h0, 80'(irq));
    $display("test instructions done");
  endtask

  task automatic t_irq();
    wr(`STU_OFF_MASK, 32'h0000_0003);
    @(negedge core_clk);
    chk("irq_on", 80'h1, 80'(irq));
    rchk("status", `STU_OFF_STATUS, 32'h0000_0002);
    chk("irq_off", 80'h0, 80'(irq));
    rchk("status_clr", `STU_OFF_STATUS, 32'h0000_0000);
    wr(`STU_OFF_CTRL, 32'h0000_0000);
    instr(3'h1, 32'h0000_7000, 10'h000, 5'h00, 5'h00, 1'b0);
    instr_end();
    repeat (20) @(posedge core_clk);
    chk("en_off", 80'h0, 80'(emu_u.len_q.size()));
    rchk("ovf_en_off", `STU_OFF_OVFCNT, 32'h0000_0000);
    wr(`STU_OFF_CTRL, 32'h0000_0001);
    $display("test interrupt done");
  endtask

  task automatic t_overflow();
    for (int i = 0; i < 10; i++) begin
      instr(3'h2, 32'h0000_5000, 10'(i), 5'h00, 5'h00, 1'b0);
    end
    instr_end();
    // Dropped tag and status read in one cycle
    @(posedge core_clk);
    tag_immediate_instr <= 1'b1;
    reg_addr <= `STU_OFF_STATUS;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    tag_immediate_instr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("status_drop", 80'h1, 80'(reg_rdata));
    for (int i = 0; i < 8; i++) begin
      get_msg("burst", {4'h4, 12'(i)}, 4, 20);
    end
    get_msg("marker", 80'hC, 1, 20);
    repeat (20) @(posedge core_clk);
    chk("no_more", 80'h0, 80'(emu_u.len_q.size()));
    rchk("ovfcnt", `STU_OFF_OVFCNT, 32'h0000_0003);
    chk("irq_ovf", 80'h1, 80'(irq));
    rchk("status_ovf", `STU_OFF_STATUS, 32'h0000_0003);
    instr(3'h2, 32'h0000_6000, 10'h2AA, 5'h00, 5'h00, 1'b0);
    instr_end();
    get_msg("after", {4'h4, 12'h2AA}, 4, 20);
    @(posedge core_clk);
    attach_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk("oe_n_det", 80'h1, 80'(link_oe_n));
    rchk("opt2_det", `STU_OFF_OPT2, `STU_RST_OPT2);
    rchk("opt0_det", `STU_OFF_OPT0, 32'h0000_0003);
    chk("stray_det", 80'h0, 80'(emu_u.stray));
    $display("test overflow done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    attach_req = 1'b0;
    {checkpoint_pc_instr, tag_immediate_instr, register_dump_instr} = 3'h0;
    instr_pc = 32'h0000_0000;
    tag_value_field = 10'h000;
    dump_lo = 5'h00;
    dump_hi = 5'h00;
    instr_with_pc = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    {reg_wr, reg_rd} = 2'h0;
    n_mismatch = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_detached();
    t_attach();
    t_instr();
    t_irq();
    t_overflow();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("MISMATCH watchdog expected finish seen hang");
    final_report();
  end
endmodule // test_stu_trace_unit

`default_nettype wire
